// >>> hw/stn_fifo2.sv
// two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stn_fifo2 (
	input  wire logic     sys_clk_i,
	input  wire logic     reset_i,
	stn_stream_if.snk     fill_s,
	stn_stream_if.src     drain_s,
	output logic [1:0]    level_o
);
	import stn_pkg::*;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][SAMPLE_W-1:0] mem;
		logic                                wp;
		logic                                rp;
		logic [1:0]                          cnt;
	} stn_fifo_st_t;

	stn_fifo_st_t q;
	stn_fifo_st_t d;
	logic         push;
	logic         pop;

	assign fill_s.ready  = (q.cnt != 2'h2);
	assign drain_s.valid = (q.cnt != 2'h0);
	assign drain_s.data  = q.mem[q.rp];
	assign level_o       = q.cnt;
	assign push          = fill_s.valid && fill_s.ready;
	assign pop           = drain_s.valid && drain_s.ready;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = fill_s.data;
			d.wp        = ~q.wp;
		end
		if (pop) begin
			d.rp = ~q.rp;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 2'h1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 2'h1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : stn_fifo2
`default_nettype wire

// >>> hw/stn_pkg.sv
// constants, types and helpers shared by the spi link tunnel
package stn_pkg;

	// register map (byte offsets on the configuration port)
	localparam logic [7:0] BC_CFG_ADDR   = 8'h23;
	localparam logic [7:0] FC_CFG_ADDR   = 8'h43;
	localparam logic [7:0] STATUS_ADDR   = 8'h44;

	// field positions
	localparam int         BC_BOOST_BIT  = 4;
	localparam int         BC_DIV_BIT    = 6;
	localparam int         MODE_LSB      = 0;
	localparam int         STAT_ACT_BIT  = 0;
	localparam int         STAT_OVF_BIT  = 1;
	localparam int         STAT_PEND_BIT = 2;
	localparam int         STAT_REV_BIT  = 3;

	// values after reset
	localparam logic [7:0] BC_CFG_RST    = 8'h00;
	localparam logic [7:0] FC_CFG_RST    = 8'h00;

	// fast channel mode codes that enable the tunnel
	localparam logic [2:0] MODE_SPI_FWD  = 3'h6;
	localparam logic [2:0] MODE_SPI_REV  = 3'h7;

	// back-channel frame period per rate, in ns, and in 50 MHz cycles
	localparam int         CLK_MHZ       = 50;
	localparam int         FRAME_NS_5M   = 7500;
	localparam int         FRAME_NS_10M  = 3750;
	localparam int         FRAME_NS_20M  = 1875;
	localparam int         CNT_W         = 9;
	localparam logic [CNT_W-1:0] FRAME_CYC_5M  = CNT_W'(FRAME_NS_5M * CLK_MHZ / 1000);
	localparam logic [CNT_W-1:0] FRAME_CYC_10M = CNT_W'(FRAME_NS_10M * CLK_MHZ / 1000);
	localparam logic [CNT_W-1:0] FRAME_CYC_20M = CNT_W'(FRAME_NS_20M * CLK_MHZ / 1000);
	localparam logic [CNT_W-1:0] CNT_ZERO      = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE       = 9'h001;
	localparam logic [CNT_W-1:0] CNT_TWO       = 9'h002;

	// sample buffer shape
	localparam int         SAMPLE_W      = 1;
	localparam int         FIFO_DEPTH    = 2;

	typedef enum logic [1:0] {
		BC_IDLE  = 2'b00,
		BC_COUNT = 2'b01,
		BC_EMIT  = 2'b11
	} stn_bc_state_t;

	function automatic logic stn_is_mode(input logic [7:0] cfg, input logic [2:0] code);
		return cfg[MODE_LSB +: 3] == code;
	endfunction : stn_is_mode

	function automatic logic [CNT_W-1:0] stn_frame_len(input logic [7:0] bc_cfg);
		if (bc_cfg[BC_BOOST_BIT]) begin
			return FRAME_CYC_20M;
		end else if (bc_cfg[BC_DIV_BIT]) begin
			return FRAME_CYC_10M;
		end
		return FRAME_CYC_5M;
	endfunction : stn_frame_len

endpackage : stn_pkg

// >>> hw/stn_spi_tunnel.sv
// spi tunnel across the secondary lane of the serial link, deserializer end
`timescale 1ns/1ps
`default_nettype none

module stn_spi_tunnel (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	// configuration register port
	input  wire logic       cfg_wr_i,
	input  wire logic       cfg_rd_i,
	input  wire logic [7:0] cfg_addr_i,
	input  wire logic [7:0] cfg_wdata_i,
	output logic      [7:0] cfg_rdata_o,
	// link status
	input  wire logic       two_lane_i,
	// forward frame fields, one strobe per pixel
	input  wire logic       fwd_valid_i,
	input  wire logic       fwd_sclk_i,
	input  wire logic       fwd_mosi_i,
	input  wire logic       fwd_ss_n_i,
	// regenerated spi outputs
	output logic            tunnel_serial_clock_o,
	output logic            spi_mosi_o,
	output logic            spi_ss_n_o,
	// local master pins, reverse mode
	input  wire logic       tunnel_serial_clock_i,
	input  wire logic       spi_mosi_i,
	input  wire logic       spi_ss_n_i,
	// back-channel frame fields
	output logic            bc_frame_o,
	output logic            bc_ss_n_o,
	output logic            bc_sample_valid_o,
	output logic            bc_mosi_o
);
	import stn_pkg::*;

	typedef struct packed {
		logic [7:0]       bc_cfg;
		logic [7:0]       fc_cfg;
		logic [7:0]       rdata;
		logic             ovf;
		logic [2:0]       sync1;
		logic [2:0]       sync2;
		logic             sclk_prev;
		logic             fsclk_dly;
		logic             sclk_o;
		logic             mosi_o;
		logic             ss_n_o;
		stn_bc_state_t    st;
		logic [CNT_W-1:0] cnt;
		logic             frame;
		logic             bc_ss_n;
		logic             bc_valid;
		logic             bc_mosi;
	} stn_top_st_t;

	localparam stn_top_st_t ST_RST = '{
		bc_cfg:    BC_CFG_RST,
		fc_cfg:    FC_CFG_RST,
		rdata:     8'h00,
		ovf:       1'b0,
		// idle pin levels, so reset leaves no false clock edge behind
		sync1:     3'h4,
		sync2:     3'h4,
		sclk_prev: 1'b0,
		fsclk_dly: 1'b0,
		sclk_o:    1'b0,
		mosi_o:    1'b0,
		ss_n_o:    1'b1,
		st:        BC_IDLE,
		cnt:       CNT_ZERO,
		frame:     1'b0,
		bc_ss_n:   1'b1,
		bc_valid:  1'b0,
		bc_mosi:   1'b0
	};

	// synchroniser bit positions
	localparam int SY_SS   = 2;
	localparam int SY_SCLK = 1;
	localparam int SY_MOSI = 0;

	stn_top_st_t     q;
	stn_top_st_t     d;
	stn_stream_if    cap_s ();
	stn_stream_if    bc_s ();
	logic [1:0]      fifo_level;
	logic            fwd_active;
	logic            rev_active;
	logic            sclk_rise;
	logic [CNT_W-1:0] frame_len;

	// synchronised pin taps, decode helpers and per-frame content
	logic            pin_ss_n;
	logic            pin_sclk;
	logic            pin_mosi;
	logic            ovf_clr;
	logic            ovf_set;
	logic            fwd_take;
	logic            data_open;
	logic            frame_due;
	logic            frame_ss_n;
	logic            frame_has;
	logic            frame_bit;
	logic [7:0]      status_byte;

	assign fwd_active = two_lane_i && stn_is_mode(q.fc_cfg, MODE_SPI_FWD);
	assign rev_active = two_lane_i && stn_is_mode(q.fc_cfg, MODE_SPI_REV);
	assign frame_len  = stn_frame_len(q.bc_cfg);

	// pin levels are read from the second synchroniser stage only
	assign pin_ss_n   = q.sync2[SY_SS];
	assign pin_sclk   = q.sync2[SY_SCLK];
	assign pin_mosi   = q.sync2[SY_MOSI];
	assign sclk_rise  = pin_sclk && !q.sclk_prev;

	// samples are taken on the rising edge; the master cannot be stalled,
	// so a full buffer is reported as overflow instead of back-pressure
	assign cap_s.valid = rev_active && sclk_rise;
	assign cap_s.data  = pin_mosi;
	assign bc_s.ready  = (q.st == BC_EMIT);

	// a capture that finds the buffer full is lost; the sticky flag keeps the evidence
	assign ovf_clr     = cfg_wr_i && cfg_addr_i == STATUS_ADDR && cfg_wdata_i[STAT_OVF_BIT];
	assign ovf_set     = cap_s.valid && !cap_s.ready;
	assign fwd_take    = fwd_active && fwd_valid_i;
	assign data_open   = !q.fsclk_dly;
	assign frame_due   = (q.cnt >= frame_len - CNT_TWO);

	// what a frame carries: the select level always, at most one data sample
	assign frame_ss_n  = pin_ss_n;
	assign frame_has   = bc_s.valid;
	assign frame_bit   = bc_s.valid && bc_s.data[0];

	// status byte; the pending bit shows samples that have not left in a frame yet
	function automatic logic [7:0] pack_status(
		input logic act,
		input logic ovf,
		input logic pend,
		input logic rev
	);
		logic [7:0] s;
		s                = 8'h00;
		s[STAT_ACT_BIT]  = act;
		s[STAT_OVF_BIT]  = ovf;
		s[STAT_PEND_BIT] = pend;
		s[STAT_REV_BIT]  = rev;
		return s;
	endfunction : pack_status

	assign status_byte = pack_status(fwd_active || rev_active, q.ovf,
	                                 fifo_level != 2'h0, rev_active);

	stn_fifo2 u_fifo (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.fill_s    (cap_s.snk),
		.drain_s   (bc_s.src),
		.level_o   (fifo_level)
	);

	always_comb begin
		d = q;

		// register writes; the tunnel itself has no path in here
		if (cfg_wr_i) begin
			case (cfg_addr_i)
				BC_CFG_ADDR: begin
					d.bc_cfg = cfg_wdata_i;
				end
				FC_CFG_ADDR: begin
					d.fc_cfg = cfg_wdata_i;
				end
				default: begin
				end
			endcase
		end

		// register and status readback
		if (cfg_rd_i) begin
			case (cfg_addr_i)
				BC_CFG_ADDR: begin
					d.rdata = q.bc_cfg;
				end
				FC_CFG_ADDR: begin
					d.rdata = q.fc_cfg;
				end
				STATUS_ADDR: begin
					d.rdata = status_byte;
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end

		// overflow: write one to clear, a new overflow in the same cycle wins
		if (ovf_clr) begin
			d.ovf = 1'b0;
		end
		if (ovf_set) begin
			d.ovf = 1'b1;
		end

		// pin synchronisers; stage one feeds stage two only
		d.sync1     = {spi_ss_n_i, tunnel_serial_clock_i, spi_mosi_i};
		d.sync2     = q.sync1;
		d.sclk_prev = pin_sclk;

		// forward regeneration on the pixel strobe; the clock leaves one strobe
		// behind its data, which buys the far slave a cycle of setup
		if (!fwd_active) begin
			d.fsclk_dly = 1'b0;
			d.sclk_o    = 1'b0;
			d.mosi_o    = 1'b0;
			d.ss_n_o    = 1'b1;
		end else if (fwd_take) begin
			d.fsclk_dly = fwd_sclk_i;
			d.sclk_o    = q.fsclk_dly;
			d.ss_n_o    = fwd_ss_n_i;
			// data moves only while the outgoing clock stays low
			if (data_open) begin
				d.mosi_o = fwd_mosi_i;
			end
		end

		// back-channel frame pacing; a frame leaves even without a sample so
		// the far end always learns the current select level
		d.frame    = 1'b0;
		d.bc_valid = 1'b0;
		if (!rev_active) begin
			d.st      = BC_IDLE;
			d.cnt     = CNT_ZERO;
			d.bc_ss_n = 1'b1;
			d.bc_mosi = 1'b0;
		end else begin
			case (q.st)
				BC_IDLE: begin
					d.st  = BC_COUNT;
					d.cnt = CNT_ZERO;
				end
				BC_COUNT: begin
					d.cnt = q.cnt + CNT_ONE;
					if (frame_due) begin
						d.st = BC_EMIT;
					end
				end
				BC_EMIT: begin
					d.frame    = 1'b1;
					d.bc_ss_n  = frame_ss_n;
					d.bc_valid = frame_has;
					d.bc_mosi  = frame_bit;
					d.st       = BC_COUNT;
					d.cnt      = CNT_ZERO;
				end
				default: begin
					d.st  = BC_IDLE;
					d.cnt = CNT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	assign cfg_rdata_o           = q.rdata;
	assign tunnel_serial_clock_o = q.sclk_o;
	assign spi_mosi_o            = q.mosi_o;
	assign spi_ss_n_o            = q.ss_n_o;
	assign bc_frame_o            = q.frame;
	assign bc_ss_n_o             = q.bc_ss_n;
	assign bc_sample_valid_o     = q.bc_valid;
	assign bc_mosi_o             = q.bc_mosi;

endmodule : stn_spi_tunnel
`default_nettype wire

// >>> hw/stn_stream_if.sv
// valid/ready sample stream between the tunnel and its buffer
`timescale 1ns/1ps
`default_nettype none
interface stn_stream_if;
	import stn_pkg::*;
	logic [SAMPLE_W-1:0] data;
	logic                valid;
	logic                ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : stn_stream_if
`default_nettype wire

// >>> verif/stn_far_model.sv
// far side model: spi master behind the serializer and on the local pins
`timescale 1ns/1ps
`default_nettype none
module stn_far_model (
	input  wire logic sys_clk_i,
	output logic      fwd_valid_o,
	output logic      fwd_sclk_o,
	output logic      fwd_mosi_o,
	output logic      fwd_ss_n_o,
	output logic      sclk_o,
	output logic      mosi_o,
	output logic      ss_n_o
);
	initial begin
		{fwd_valid_o, fwd_sclk_o, fwd_mosi_o, fwd_ss_n_o} = 4'h1;
		{sclk_o, mosi_o, ss_n_o} = 3'h1;
	end
	// forward write, two strobes per level, slave output ignored
	task automatic fwd_byte(input logic [7:0] b);
		@(posedge sys_clk_i);
		fwd_valid_o <= 1'b1;
		fwd_ss_n_o <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fwd_mosi_o <= b[i];
			fwd_sclk_o <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
			fwd_sclk_o <= 1'b1;
			repeat (2) @(posedge sys_clk_i);
		end
		fwd_sclk_o <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		fwd_ss_n_o <= 1'b1;
		fwd_mosi_o <= ~b[0];
		repeat (2) @(posedge sys_clk_i);
		fwd_valid_o <= 1'b0;
	endtask : fwd_byte
	// reverse: 160 ns clock from four-cycle halves, pulses gap cycles apart so each
	// bit waits out the link round trip; levels change four cycles before each rising edge
	task automatic rev_bits(input logic [7:0] b, input int n, input int gap, input int hold);
		@(posedge sys_clk_i);
		ss_n_o <= 1'b0;
		repeat (gap) @(posedge sys_clk_i);
		for (int i = 7; i > 7 - n; i--) begin
			mosi_o <= b[i];
			repeat (4) @(posedge sys_clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			sclk_o <= 1'b0;
			repeat (gap) @(posedge sys_clk_i);
		end
		ss_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
		repeat (hold) @(posedge sys_clk_i);
	endtask : rev_bits
endmodule : stn_far_model
`default_nettype wire

// >>> verif/stn_spi_tunnel_checker.sv
// port checker for the spi link tunnel
`timescale 1ns/1ps
`default_nettype none
module stn_spi_tunnel_checker (
	input wire logic       sys_clk_i,
	input wire logic       reset_i,
	input wire logic       cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	input wire logic       two_lane_i,
	input wire logic       fwd_valid_i,
	input wire logic       fwd_sclk_i,
	input wire logic       fwd_ss_n_i,
	input wire logic       spi_ss_n_i,
	input wire logic       tunnel_serial_clock_o,
	input wire logic       spi_mosi_o,
	input wire logic       spi_ss_n_o,
	input wire logic       bc_frame_o,
	input wire logic       bc_ss_n_o,
	input wire logic       bc_sample_valid_o
);
	import stn_pkg::*;
	logic [2:0] mode_q;
	logic [7:0] bc_q;
	logic [8:0] gap_q, per;
	logic       seen_q, fwd_on, rev_on;
	assign fwd_on = two_lane_i && mode_q == MODE_SPI_FWD;
	assign rev_on = two_lane_i && mode_q == MODE_SPI_REV;
	// rate bits must not change while reverse runs, the shadow cannot follow that
	assign per = bc_q[BC_BOOST_BIT] ? 9'h05d : (bc_q[BC_DIV_BIT] ? 9'h0bb : 9'h177);
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_q <= 3'h0;
			bc_q <= 8'h00;
			gap_q <= 9'h000;
			seen_q <= 1'b0;
		end else begin
			if (cfg_wr_i && cfg_addr_i == FC_CFG_ADDR) mode_q <= cfg_wdata_i[2:0];
			if (cfg_wr_i && cfg_addr_i == BC_CFG_ADDR) bc_q <= cfg_wdata_i;
			gap_q <= bc_frame_o ? 9'h001 : gap_q + 9'h001;
			seen_q <= rev_on && (seen_q || bc_frame_o);
		end
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	AST_FWD_SS: assert property (fwd_on && fwd_valid_i |=> spi_ss_n_o == $past(fwd_ss_n_i))
		else $error("select not rebuilt");
	AST_FWD_LAG: assert property (
		fwd_valid_i && $past(fwd_valid_i) && fwd_on && $past(fwd_on)
		|=> tunnel_serial_clock_o == $past(fwd_sclk_i, 2)) else $error("clock lag wrong");
	AST_MOSI_HOLD: assert property (tunnel_serial_clock_o |-> $stable(spi_mosi_o))
		else $error("data moved under high clock");
	AST_FWD_IDLE: assert property (
		!fwd_on |=> !tunnel_serial_clock_o && !spi_mosi_o && spi_ss_n_o)
		else $error("forward outputs not idle");
	AST_BC_IDLE: assert property (!rev_on |=> !bc_frame_o && bc_ss_n_o)
		else $error("back channel not idle");
	AST_PERIOD: assert property (bc_frame_o && seen_q |-> gap_q == per)
		else $error("frame spacing wrong");
	AST_ONE_SAMPLE: assert property (bc_sample_valid_o |-> bc_frame_o ##1 !bc_frame_o)
		else $error("sample outside one frame");
	AST_SS_CARRY: assert property (
		bc_frame_o && $past(spi_ss_n_i, 2) == $past(spi_ss_n_i, 8)
		|-> bc_ss_n_o == $past(spi_ss_n_i, 4)) else $error("frame select wrong");
endmodule : stn_spi_tunnel_checker
`default_nettype wire

// >>> verif/test_stn_spi_tunnel.sv
// self-checking bench for the spi link tunnel
`timescale 1ns/1ps
`default_nettype none
module test_stn_spi_tunnel;
	import stn_pkg::*;
	logic       sys_clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       cfg_wr_i = 1'b0;
	logic       cfg_rd_i = 1'b0;
	logic       two_lane_i = 1'b1;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic [7:0] cfg_rdata_o;
	logic       fwd_valid_i, fwd_sclk_i, fwd_mosi_i, fwd_ss_n_i;
	logic       tunnel_serial_clock_i, spi_mosi_i, spi_ss_n_i;
	logic       tunnel_serial_clock_o, spi_mosi_o, spi_ss_n_o;
	logic       bc_frame_o, bc_ss_n_o, bc_sample_valid_o, bc_mosi_o;
	int         bad_count = 0;
	int         cmp_count = 0;
	always #10 sys_clk_i = ~sys_clk_i;
	stn_spi_tunnel i_stn_spi_tunnel (.*);
	stn_far_model i_stn_far_model (
		.sys_clk_i,
		.fwd_valid_o(fwd_valid_i),
		.fwd_sclk_o(fwd_sclk_i),
		.fwd_mosi_o(fwd_mosi_i),
		.fwd_ss_n_o(fwd_ss_n_i),
		.sclk_o(tunnel_serial_clock_i),
		.mosi_o(spi_mosi_i),
		.ss_n_o(spi_ss_n_i)
	);
	task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		cfg_wr_i <= 1'b1;
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		@(posedge sys_clk_i);
		cfg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk_i);
		cfg_rd_i <= 1'b1;
		cfg_addr_i <= a;
		@(posedge sys_clk_i);
		cfg_rd_i <= 1'b0;
		#1 chk(what, {1'b0, cfg_rdata_o}, {1'b0, exp});
	endtask : rd
	// forward byte rebuilt, sampled at each rising regenerated clock
	task automatic t_fwd(input logic [7:0] b, input logic [7:0] mode, input logic lanes);
		logic [7:0] got;
		logic       prev, busy;
		got = 8'h00;
		prev = 1'b0;
		busy = 1'b0;
		two_lane_i <= lanes;
		wr(FC_CFG_ADDR, mode);
		fork
			i_stn_far_model.fwd_byte(b);
			repeat (60) begin
				@(negedge sys_clk_i);
				if (tunnel_serial_clock_o && !prev) got = {got[6:0], spi_mosi_o};
				busy = busy | tunnel_serial_clock_o | spi_mosi_o | !spi_ss_n_o;
				prev = tunnel_serial_clock_o;
			end
		join
		chk("fwd byte", {1'b0, got}, (lanes && mode == 8'h06) ? {1'b0, b} : 9'h000);
		chk("fwd busy", {8'h00, busy}, {8'h00, lanes && mode == 8'h06});
		two_lane_i <= 1'b1;
	endtask : t_fwd
	// reverse byte crosses one bit per frame, period per rate setting
	task automatic t_rev(input logic [7:0] cfg, input int fns, input logic [7:0] b);
		logic [7:0] got;
		logic       sel;
		int         n, last, per;
		{got, n, last, per} = '0;
		sel = 1'b0;
		wr(FC_CFG_ADDR, 8'h00);
		wr(BC_CFG_ADDR, cfg);
		wr(FC_CFG_ADDR, {5'h00, MODE_SPI_REV});
		fork
			i_stn_far_model.rev_bits(b, 8, fns / 20 + 5, fns / 20);
			for (int c = 0; c < 12 * fns / 20; c++) begin
				@(negedge sys_clk_i);
				if (bc_frame_o) begin
					per = c - last;
					last = c;
				end
				if (bc_frame_o && !bc_ss_n_o) sel = 1'b1;
				if (bc_sample_valid_o) begin
					got = {got[6:0], bc_mosi_o};
					n++;
				end
			end
		join
		chk("rev byte", {1'b0, got}, {1'b0, b});
		chk("rev samples", 9'(n), 9'h008);
		chk("rev select", {8'h00, sel}, 9'h001);
		chk("frame period", 9'(per), 9'(fns * CLK_MHZ / 1000));
	endtask : t_rev
	// burst overruns the two-entry buffer, then frames drain it
	task automatic t_ovf();
		wr(FC_CFG_ADDR, 8'h00);
		wr(BC_CFG_ADDR, 8'h00);
		wr(FC_CFG_ADDR, {5'h00, MODE_SPI_REV});
		i_stn_far_model.rev_bits(8'ha0, 4, 0, 5);
		rd(STATUS_ADDR, 8'h0f, "status full");
		repeat (3 * 375) @(posedge sys_clk_i);
		rd(STATUS_ADDR, 8'h0b, "status drained");
		wr(STATUS_ADDR, 8'h02);
		rd(STATUS_ADDR, 8'h09, "status cleared");
	endtask : t_ovf
	initial begin
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(FC_CFG_ADDR, FC_CFG_RST, "mode reset");
		rd(BC_CFG_ADDR, BC_CFG_RST, "rate reset");
		rd(8'h10, 8'h00, "unmapped");
		t_fwd(8'ha5, 8'h06, 1'b1);
		rd(FC_CFG_ADDR, 8'h06, "mode kept");
		t_fwd(8'h5a, 8'h06, 1'b0);
		t_fwd(8'h3c, 8'h05, 1'b1);
		t_rev(8'h00, FRAME_NS_5M, 8'h96);
		t_rev(8'h40, FRAME_NS_10M, 8'h3c);
		t_rev(8'h50, FRAME_NS_20M, 8'hc5);
		t_ovf();
		final_report();
	end
endmodule : test_stn_spi_tunnel
bind stn_spi_tunnel stn_spi_tunnel_checker i_stn_spi_tunnel_checker (.*);
`default_nettype wire
